// ===== pkg/ncd_pkg.sv
// Purpose: Shared constants for the NAND configuration block decoder.
// Assumes: 40 MHz pclk, APB register access, 256-byte configuration image.
// Notes: Field offsets are byte offsets inside the image.
// Overview of operation
// - Strobe gaps use low nibble, plus one cycle.
// - Write rise to read fall gap timed.
// - Read rise to write fall gap timed.
// - Busy indication valid after write rise gap.
// - Poll method: 0 status, 1 pin.
// - Poll timeout after millisecond limit, reported.
// - Poll checks spaced by microsecond interval.
// - ECC source: 0 on-die, 1 external.
// - On-die ECC default: 0 enabled, 1 disabled.
// - Soft ECC chunk size from four bytes.
// - Timing mode 0 user, 1-6 ONFI, 7 fastest.
// - Custom timing code held separately.
// - Page main size from four bytes.
// - Page spare size from separate field.
// - Verify buffer address from its field.
// - Image is 256 bytes, fixed offsets.
package ncd_pkg;
  localparam int CFG_BYTES = 256;
  localparam int CFG_WORDS = CFG_BYTES / 4;
  localparam logic [7:0] OFF_WR_RD_GAP = 8'h47;
  localparam logic [7:0] OFF_RD_WR_GAP = 8'h48;
  localparam logic [7:0] OFF_WR_BUSY_GAP = 8'h4b;
  localparam logic [7:0] OFF_TMODE = 8'h53;
  localparam logic [7:0] OFF_ECC_SRC = 8'h55;
  localparam logic [7:0] OFF_ONDIE = 8'h56;
  localparam logic [7:0] OFF_CHUNK = 8'h58;
  localparam logic [7:0] OFF_METHOD = 8'h5c;
  localparam logic [7:0] OFF_TMO_MS = 8'h5e;
  localparam logic [7:0] OFF_SPC_US = 8'h60;
  localparam logic [7:0] OFF_TCODE = 8'h80;
  localparam logic [7:0] OFF_MAIN = 8'ha0;
  localparam logic [7:0] OFF_EXTRA = 8'ha4;
  localparam logic [7:0] OFF_VBUF = 8'he4;
  localparam logic [7:0] MAX_BINARY_SEL = 8'h01;
  localparam logic [7:0] MAX_TMODE_SEL = 8'h07;
  localparam logic METHOD_PIN = 1'b1;
  localparam logic [11:0] ADDR_CFG_END = 12'h100;
  localparam logic [11:0] ADDR_CTRL = 12'h100;
  localparam logic [11:0] ADDR_STATUS = 12'h104;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h108;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h10c;
  localparam int CTRL_APPLY = 0;
  localparam int CTRL_POLL = 1;
  localparam int IRQ_CFG_ERR = 0;
  localparam int IRQ_POLL_DONE = 1;
  localparam int IRQ_POLL_TMO = 2;
  localparam int IRQ_BITS = 3;
  localparam longint CLK_HZ = 40000000;
  localparam longint HZ_PER_MHZ = 1000000;
  localparam int US_CYCLES = int'(CLK_HZ / HZ_PER_MHZ);
  localparam int US_PER_MS = 1000;
  typedef enum logic [1:0] {NCD_IDLE, NCD_SPACE, NCD_CHECK} ncd_poll_t;
endpackage

// ===== verilog/ncd_top.sv
// Purpose: Holds a NAND configuration image, decodes it, and runs strobe gap and ready poll timing.
// Assumes: Strobe engine and status reader share pclk; inputs are synchronous to pclk.
// Notes: Decoded outputs only change on an accepted apply.
`timescale 1ns/1ps
module ncd_top
  import ncd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wr_strobe_rise,
  input wire logic rd_strobe_rise,
  input wire logic ready_busy_pin,
  input wire logic status_valid,
  input wire logic status_ready,
  output logic rd_fall_ok,
  output logic wr_fall_ok,
  output logic busy_valid,
  output logic poll_check,
  output logic poll_busy,
  output logic cfg_valid,
  output logic [4:0] wr_rise_to_rd_fall_gap,
  output logic [4:0] rd_rise_to_wr_fall_gap,
  output logic [4:0] wr_rise_to_busy_gap,
  output logic ready_poll_method,
  output logic [15:0] ready_poll_timeout_ms,
  output logic [15:0] ready_poll_spacing_us,
  output logic ecc_source_select,
  output logic ondie_ecc_default,
  output logic [31:0] soft_ecc_chunk_size,
  output logic [2:0] timing_mode_select,
  output logic [7:0] custom_timing_code,
  output logic [31:0] page_main_size,
  output logic [31:0] page_extra_size,
  output logic [31:0] verify_buffer_addr,
  output logic irq
);
  typedef struct packed {
    logic [CFG_WORDS-1:0][31:0] mem;
    logic cfg_valid;
    logic [2:0][3:0] gap_val;
    logic [2:0][4:0] gap_cnt;
    logic method;
    logic ecc_src;
    logic ondie;
    logic [2:0] tmode;
    logic [7:0] tcode;
    logic [15:0] tmo_ms;
    logic [15:0] spc_us;
    logic [31:0] chunk;
    logic [31:0] main_sz;
    logic [31:0] extra_sz;
    logic [31:0] vbuf;
    ncd_poll_t pst;
    logic [5:0] us_div;
    logic [5:0] to_div;
    logic [9:0] ms_div;
    logic [15:0] us_cnt;
    logic [15:0] ms_cnt;
    logic poll_check;
    logic [IRQ_BITS-1:0] irq_stat;
    logic [IRQ_BITS-1:0] irq_mask;
    logic [31:0] rdata;
  } ncd_state_t;

  ncd_state_t q;
  ncd_state_t n;

  localparam logic [5:0] US_LAST = 6'(US_CYCLES - 1);
  localparam logic [9:0] MS_LAST = 10'(US_PER_MS - 1);

  function automatic logic [7:0] cfg_byte(input logic [CFG_WORDS-1:0][31:0] m, input logic [7:0] off);
    return m[off[7:2]][{off[1:0], 3'b000} +: 8];
  endfunction

  function automatic logic [31:0] cfg_word(input logic [CFG_WORDS-1:0][31:0] m, input logic [7:0] off);
    return {cfg_byte(m, off + 8'h03), cfg_byte(m, off + 8'h02), cfg_byte(m, off + 8'h01), cfg_byte(m, off)};
  endfunction

  function automatic logic [4:0] gap_cycles(input logic [3:0] nib);
    return {1'b0, nib} + 5'h01;
  endfunction

  // Only the low nibble of a strobe gap byte counts
  function automatic logic [3:0] cfg_nib(input logic [CFG_WORDS-1:0][31:0] m, input logic [7:0] off);
    logic [7:0] b;
    b = cfg_byte(m, off);
    return b[3:0];
  endfunction

  logic setup_ph;
  logic wr_acc;
  logic cfg_hit;
  logic mapped;
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign cfg_hit = paddr < ADDR_CFG_END;
  assign mapped = cfg_hit || paddr == ADDR_CTRL || paddr == ADDR_STATUS || paddr == ADDR_IRQ_STAT ||
    paddr == ADDR_IRQ_MASK;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb
  begin
    logic [IRQ_BITS-1:0] ev;
    logic [IRQ_BITS-1:0] w1c;
    logic [2:0] trig;
    logic [7:0] b_method;
    logic [7:0] b_ecc;
    logic [7:0] b_ondie;
    logic [7:0] b_tmode;
    logic sel_ok;
    logic us_tick;
    logic to_tick;
    logic decided;
    logic ready_now;
    ev = '0;
    w1c = '0;
    trig = {wr_strobe_rise, rd_strobe_rise, wr_strobe_rise};
    b_method = cfg_byte(q.mem, OFF_METHOD);
    b_ecc = cfg_byte(q.mem, OFF_ECC_SRC);
    b_ondie = cfg_byte(q.mem, OFF_ONDIE);
    b_tmode = cfg_byte(q.mem, OFF_TMODE);
    sel_ok = 1'b0;
    us_tick = 1'b0;
    to_tick = 1'b0;
    decided = 1'b0;
    ready_now = 1'b0;
    n = q;
    n.poll_check = 1'b0;

    // Read data is captured in the setup phase so the access phase needs no wait state
    if (setup_ph)
    begin
      if (cfg_hit)
        n.rdata = q.mem[paddr[7:2]];
      else if (paddr == ADDR_STATUS)
        n.rdata = {30'h0, q.pst != NCD_IDLE, q.cfg_valid};
      else if (paddr == ADDR_IRQ_STAT)
        n.rdata = {29'h0, q.irq_stat};
      else if (paddr == ADDR_IRQ_MASK)
        n.rdata = {29'h0, q.irq_mask};
      else
        n.rdata = 32'h0;
    end

    if (wr_acc && cfg_hit)
    begin
      for (int b = 0; b < 4; b++)
        if (pstrb[b])
          n.mem[paddr[7:2]][8*b +: 8] = pwdata[8*b +: 8];
    end
    if (wr_acc && paddr == ADDR_IRQ_MASK)
      n.irq_mask = pwdata[IRQ_BITS-1:0];
    if (wr_acc && paddr == ADDR_IRQ_STAT)
      w1c = pwdata[IRQ_BITS-1:0];

    // Apply: a bad selector leaves the previous settings in place and drops valid
    if (wr_acc && paddr == ADDR_CTRL && pwdata[CTRL_APPLY])
    begin
      sel_ok = b_method <= MAX_BINARY_SEL && b_ecc <= MAX_BINARY_SEL && b_ondie <= MAX_BINARY_SEL &&
        b_tmode <= MAX_TMODE_SEL;
      n.cfg_valid = sel_ok;
      if (!sel_ok)
        ev[IRQ_CFG_ERR] = 1'b1;
      else
      begin
        n.gap_val[0] = cfg_nib(q.mem, OFF_WR_RD_GAP);
        n.gap_val[1] = cfg_nib(q.mem, OFF_RD_WR_GAP);
        n.gap_val[2] = cfg_nib(q.mem, OFF_WR_BUSY_GAP);
        n.method = b_method[0];
        n.ecc_src = b_ecc[0];
        n.ondie = b_ondie[0];
        n.tmode = b_tmode[2:0];
        n.tcode = cfg_byte(q.mem, OFF_TCODE);
        n.tmo_ms = {cfg_byte(q.mem, OFF_TMO_MS + 8'h01), cfg_byte(q.mem, OFF_TMO_MS)};
        n.spc_us = {cfg_byte(q.mem, OFF_SPC_US + 8'h01), cfg_byte(q.mem, OFF_SPC_US)};
        n.chunk = cfg_word(q.mem, OFF_CHUNK);
        n.main_sz = cfg_word(q.mem, OFF_MAIN);
        n.extra_sz = cfg_word(q.mem, OFF_EXTRA);
        n.vbuf = cfg_word(q.mem, OFF_VBUF);
      end
    end

    // Gap timers run on pclk, the same clock that paces the strobes
    for (int i = 0; i < 3; i++)
    begin
      if (trig[i])
        n.gap_cnt[i] = gap_cycles(q.gap_val[i]);
      else if (q.gap_cnt[i] != 5'h00)
        n.gap_cnt[i] = q.gap_cnt[i] - 5'h01;
    end

    // Ready poll timebase only runs while a poll is active
    if (q.pst != NCD_IDLE)
    begin
      if (q.us_div == US_LAST)
      begin
        n.us_div = 6'h00;
        us_tick = 1'b1;
      end
      else
        n.us_div = q.us_div + 6'h01;
      if (us_tick)
        n.us_cnt = q.us_cnt + 16'h0001;
      // The timeout has its own divider: re-spacing restarts us_div and would otherwise stall it
      if (q.to_div == US_LAST)
      begin
        n.to_div = 6'h00;
        to_tick = 1'b1;
      end
      else
        n.to_div = q.to_div + 6'h01;
      if (to_tick)
      begin
        if (q.ms_div == MS_LAST)
        begin
          n.ms_div = 10'h000;
          n.ms_cnt = q.ms_cnt + 16'h0001;
        end
        else
          n.ms_div = q.ms_div + 10'h001;
      end
    end

    case (q.pst)
      NCD_IDLE:
        if (wr_acc && paddr == ADDR_CTRL && pwdata[CTRL_POLL] && q.cfg_valid)
        begin
          n.pst = NCD_SPACE;
          n.us_div = 6'h00;
          n.to_div = 6'h00;
          n.ms_div = 10'h000;
          n.us_cnt = 16'h0000;
          n.ms_cnt = 16'h0000;
        end
      NCD_SPACE:
        if (q.us_cnt >= q.spc_us)
        begin
          n.pst = NCD_CHECK;
          n.poll_check = 1'b1;
        end
      NCD_CHECK:
      begin
        if (q.method == METHOD_PIN)
        begin
          decided = 1'b1;
          ready_now = ready_busy_pin;
        end
        else
        begin
          decided = status_valid;
          ready_now = status_ready;
        end
        if (decided && ready_now)
        begin
          ev[IRQ_POLL_DONE] = 1'b1;
          n.pst = NCD_IDLE;
        end
        else if (decided)
        begin
          n.pst = NCD_SPACE;
          n.us_cnt = 16'h0000;
          n.us_div = 6'h00;
        end
      end
      default:
        n.pst = NCD_IDLE;
    endcase

    // A ready answer in the same cycle as the limit wins over the timeout
    if (q.pst != NCD_IDLE && !ev[IRQ_POLL_DONE] && q.ms_cnt >= q.tmo_ms)
    begin
      ev[IRQ_POLL_TMO] = 1'b1;
      n.pst = NCD_IDLE;
      n.poll_check = 1'b0;
    end

    // New events win over a software clear in the same cycle
    n.irq_stat = (q.irq_stat & ~w1c) | ev;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= n;
  end

  assign prdata = q.rdata;
  assign rd_fall_ok = q.gap_cnt[0] == 5'h00;
  assign wr_fall_ok = q.gap_cnt[1] == 5'h00;
  assign busy_valid = q.gap_cnt[2] == 5'h00;
  assign poll_check = q.poll_check;
  assign poll_busy = q.pst != NCD_IDLE;
  assign cfg_valid = q.cfg_valid;
  assign wr_rise_to_rd_fall_gap = gap_cycles(q.gap_val[0]);
  assign rd_rise_to_wr_fall_gap = gap_cycles(q.gap_val[1]);
  assign wr_rise_to_busy_gap = gap_cycles(q.gap_val[2]);
  assign ready_poll_method = q.method;
  assign ready_poll_timeout_ms = q.tmo_ms;
  assign ready_poll_spacing_us = q.spc_us;
  assign ecc_source_select = q.ecc_src;
  assign ondie_ecc_default = q.ondie;
  assign soft_ecc_chunk_size = q.chunk;
  assign timing_mode_select = q.tmode;
  assign custom_timing_code = q.tcode;
  assign page_main_size = q.main_sz;
  assign page_extra_size = q.extra_sz;
  assign verify_buffer_addr = q.vbuf;
  assign irq = |(q.irq_stat & q.irq_mask);

  logic [4:0] since_wr_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      since_wr_q <= 5'h00;
    else if (wr_strobe_rise)
      since_wr_q <= 5'h00;
    else if (since_wr_q != 5'h1f)
      since_wr_q <= since_wr_q + 5'h01;
  end

  gap_exact_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(rd_fall_ok) |-> since_wr_q == wr_rise_to_rd_fall_gap)
    else $error("read fall gap length wrong");
  rdwr_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_strobe_rise |=> !wr_fall_ok)
    else $error("write fall allowed too soon");
  busy_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_strobe_rise |=> !busy_valid)
    else $error("busy valid too soon");
  busy_exact_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy_valid) |-> since_wr_q == wr_rise_to_busy_gap)
    else $error("busy gap length wrong");
  pin_method_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(q.irq_stat[IRQ_POLL_DONE]) && ready_poll_method == METHOD_PIN |-> $past(ready_busy_pin))
    else $error("pin poll done without ready pin");
  status_method_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(q.irq_stat[IRQ_POLL_DONE]) && ready_poll_method != METHOD_PIN |-> $past(status_valid && status_ready))
    else $error("status poll done without ready status");
  tmo_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(q.irq_stat[IRQ_POLL_TMO]) |-> !poll_busy && $past(poll_busy))
    else $error("timeout without stopping poll");
  spacing_a: assert property (@(posedge pclk) disable iff (!presetn)
    poll_check && ready_poll_spacing_us != 16'h0000 |=> !poll_check [*8])
    else $error("poll checks too close");
  reject_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(q.irq_stat[IRQ_CFG_ERR]) |-> !cfg_valid)
    else $error("bad selector accepted");
  mode_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(timing_mode_select) |-> cfg_valid)
    else $error("timing mode changed without valid apply");
endmodule

// ===== test/ncd_flash_model.sv
// Purpose: Flash side of ready polling, answering on the pin and by status reads.
// Assumes: poll_check is a one-cycle pulse on pclk.
// Notes: Status answers come three cycles after a check; arm clears the check count.
`timescale 1ns/1ps
module ncd_flash_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic poll_check,
  input wire logic arm,
  input wire logic [3:0] ready_after,
  input wire logic stat_ok,
  output logic ready_busy_pin,
  output logic status_valid,
  output logic status_ready
);
  logic [3:0] n_q;
  logic [2:0] dly_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      n_q <= 4'h0;
      dly_q <= 3'h0;
    end
    else
    begin
      if (arm)
        n_q <= 4'h0;
      else if (poll_check && n_q != 4'hf)
        n_q <= n_q + 4'h1;
      dly_q <= {dly_q[1:0], poll_check};
    end
  end
  assign ready_busy_pin = n_q >= ready_after;
  assign status_valid = dly_q[2];
  // Outside an answer the ready bit toggles so that a stale read cannot pass
  assign status_ready = status_valid ? (ready_busy_pin & stat_ok) : n_q[0];
endmodule

// ===== test/testbench.sv
// Purpose: Self-checking bench for the configuration decoder.
// Assumes: Zero-wait APB slave; flash model on the poll side.
// Notes: Image bytes come from an LFSR; selectors are masked legal except in reject tests.
`timescale 1ns/1ps
module testbench;
  import ncd_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [3:0] pstrb = 4'hf, ready_after = 4'h0;
  logic pready, pslverr, e, irq, arm = 1'b0, stat_ok = 1'b0, wr_strobe_rise = 1'b0, rd_strobe_rise = 1'b0;
  logic ready_busy_pin, status_valid, status_ready, rd_fall_ok, wr_fall_ok, busy_valid, poll_check, poll_busy;
  logic cfg_valid, ready_poll_method, ecc_source_select, ondie_ecc_default;
  logic [4:0] wr_rise_to_rd_fall_gap, rd_rise_to_wr_fall_gap, wr_rise_to_busy_gap;
  logic [15:0] ready_poll_timeout_ms, ready_poll_spacing_us, lf = 16'haae1;
  logic [31:0] soft_ecc_chunk_size, page_main_size, page_extra_size, verify_buffer_addr;
  logic [2:0] timing_mode_select;
  logic [7:0] custom_timing_code, img [256];
  int fail_count = 0, compares = 0, cyc = 0, n, k;
  logic [7:0] bad_off [4] = '{OFF_METHOD, OFF_ECC_SRC, OFF_ONDIE, OFF_TMODE};
  logic [7:0] bad_val [4] = '{8'h02, 8'h02, 8'h02, 8'h08};
  ncd_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .wr_strobe_rise, .rd_strobe_rise, .ready_busy_pin, .status_valid, .status_ready, .rd_fall_ok, .wr_fall_ok,
    .busy_valid, .poll_check, .poll_busy, .cfg_valid, .wr_rise_to_rd_fall_gap, .rd_rise_to_wr_fall_gap,
    .wr_rise_to_busy_gap, .ready_poll_method, .ready_poll_timeout_ms, .ready_poll_spacing_us, .ecc_source_select,
    .ondie_ecc_default, .soft_ecc_chunk_size, .timing_mode_select, .custom_timing_code, .page_main_size,
    .page_extra_size, .verify_buffer_addr, .irq);
  ncd_flash_model i_flash (.pclk, .presetn, .poll_check, .arm, .ready_after, .stat_ok, .ready_busy_pin,
    .status_valid, .status_ready);
  always #12.5 pclk = ~pclk;
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] le32(input int o);
    return {img[o + 3], img[o + 2], img[o + 1], img[o]};
  endfunction
  function automatic logic [31:0] gp(input int o);
    return {28'h0, img[o][3:0]} + 32'h1;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic put(input logic [7:0] o, input logic [7:0] v);
    img[o] = v;
    apb(1'b1, {4'h0, o[7:2], 2'b00}, le32({o[7:2], 2'b00}));
  endtask
  task automatic gap(input int s, input int o);
    @(posedge pclk);
    if (s == 1)
      rd_strobe_rise <= 1'b1;
    else
      wr_strobe_rise <= 1'b1;
    @(posedge pclk);
    wr_strobe_rise <= 1'b0;
    rd_strobe_rise <= 1'b0;
    n = 0;
    do
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    while ((s == 0 ? rd_fall_ok : s == 1 ? wr_fall_ok : busy_valid) !== 1'b1 && n < 40);
    chk("gap cycles", n, gp(o));
  endtask
  task automatic poll_wait(input int lim);
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_POLL);
    n = 0;
    k = 0;
    while (poll_busy !== 1'b0 || n < 2)
    begin
      @(posedge pclk);
      #1;
      n++;
      k += (poll_check === 1'b1);
      if (n > lim)
        break;
    end
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      fail_count++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("reset gap", wr_rise_to_rd_fall_gap, 32'h1);
    chk("reset irq", irq, 32'h0);
    for (int it = 0; it < 3; it++)
    begin
      for (int i = 0; i < CFG_BYTES; i++)
      begin
        lf = nx(lf);
        img[i] = lf[7:0];
      end
      // Corner passes: all-ones and all-zero nibbles under random upper bits
      for (int o = 8'h47; o <= 8'h4b; o++)
        img[o][3:0] = it == 0 ? 4'hf : it == 1 ? 4'h0 : img[o][3:0];
      img[OFF_METHOD] &= 8'h01;
      img[OFF_ECC_SRC] &= 8'h01;
      img[OFF_ONDIE] &= 8'h01;
      img[OFF_TMODE] &= 8'h07;
      for (int w = 0; w < CFG_WORDS; w++)
        apb(1'b1, 12'(w * 4), le32(w * 4));
      apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_APPLY);
      repeat (2) @(posedge pclk);
      chk("cfg_valid", cfg_valid, 32'h1);
      chk("gap rd", wr_rise_to_rd_fall_gap, gp(OFF_WR_RD_GAP));
      chk("gap wr", rd_rise_to_wr_fall_gap, gp(OFF_RD_WR_GAP));
      chk("gap busy", wr_rise_to_busy_gap, gp(OFF_WR_BUSY_GAP));
      chk("method", ready_poll_method, img[OFF_METHOD]);
      chk("timeout", ready_poll_timeout_ms, le32(OFF_TMO_MS) & 32'hffff);
      chk("spacing", ready_poll_spacing_us, le32(OFF_SPC_US) & 32'hffff);
      chk("ecc src", ecc_source_select, img[OFF_ECC_SRC]);
      chk("ondie", ondie_ecc_default, img[OFF_ONDIE]);
      chk("chunk", soft_ecc_chunk_size, le32(OFF_CHUNK));
      chk("tmode", timing_mode_select, img[OFF_TMODE]);
      chk("tcode", custom_timing_code, img[OFF_TCODE]);
      chk("main", page_main_size, le32(OFF_MAIN));
      chk("extra", page_extra_size, le32(OFF_EXTRA));
      chk("vbuf", verify_buffer_addr, le32(OFF_VBUF));
      apb(1'b0, 12'h0a4, 32'h0);
      chk("readback", q, le32(OFF_EXTRA));
      gap(0, OFF_WR_RD_GAP);
      gap(1, OFF_RD_WR_GAP);
      gap(2, OFF_WR_BUSY_GAP);
    end
    $display("test decode done");
    apb(1'b0, 12'h200, 32'h0);
    chk("unmapped data", q, 32'h0);
    chk("unmapped err", e, 32'h1);
    for (int b = 0; b < 4; b++)
    begin
      apb(1'b1, ADDR_IRQ_MASK, 32'h0);
      k = img[bad_off[b]];
      put(bad_off[b], bad_val[b]);
      apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_APPLY);
      repeat (2) @(posedge pclk);
      chk("rejected", cfg_valid, 32'h0);
      chk("kept tmode", timing_mode_select, b == 3 ? k : img[OFF_TMODE]);
      chk("masked irq", irq, 32'h0);
      apb(1'b1, ADDR_IRQ_MASK, 32'h1 << IRQ_CFG_ERR);
      #1;
      chk("irq on", irq, 32'h1);
      apb(1'b1, ADDR_IRQ_STAT, 32'h7);
      apb(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk("stat clear", q, 32'h0);
      put(bad_off[b], 8'(k));
    end
    $display("test reject done");
    put(OFF_METHOD, 8'h01);
    put(8'h5e, 8'h05);
    put(8'h5f, 8'h00);
    put(8'h60, 8'h01);
    put(8'h61, 8'h00);
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_APPLY);
    apb(1'b1, ADDR_IRQ_MASK, 32'h7);
    @(posedge pclk);
    arm <= 1'b1;
    ready_after <= 4'h2;
    @(posedge pclk);
    arm <= 1'b0;
    poll_wait(2000);
    chk("pin checks", k, 32'h3);
    chk("spaced", 32'(n >= 3 * US_CYCLES && n <= 3 * US_CYCLES + 20), 32'h1);
    chk("done irq", irq, 32'h1);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("done stat", q, 32'h1 << IRQ_POLL_DONE);
    apb(1'b1, ADDR_IRQ_STAT, 32'h7);
    put(OFF_METHOD, 8'h00);
    put(8'h5e, 8'h01);
    put(8'h60, 8'h00);
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_APPLY);
    ready_after <= 4'h0;
    poll_wait(45000);
    chk("timeout time", 32'(n >= US_CYCLES * US_PER_MS - 5 && n <= US_CYCLES * US_PER_MS + 50), 32'h1);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("timeout stat", q, 32'h1 << IRQ_POLL_TMO);
    apb(1'b1, ADDR_IRQ_STAT, 32'h7);
    stat_ok <= 1'b1;
    poll_wait(2000);
    chk("status quick", 32'(n <= 10), 32'h1);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("status done", q, 32'h1 << IRQ_POLL_DONE);
    $display("test poll done");
    give_verdict();
  end
endmodule
